// *** verilog/dpsd_ctrl.sv ***
// SDRAM command, address, data and carrier management engine for two memory carriers.
// Contract
// - Two complete, separate pin sets are driven, one per memory carrier.
// - Each port drives a two-bit bank address in both the row and the column phase.
// - Each port drives a 13-bit address carrying the row, then the column.
// - Each port has eight chip selects, each shared by four DIMMs.
// - Only one row strobe and one column strobe are active during an access.
// - Eight chip selects times four strobe groups reach 32 DIMMs per port.
// - The low row strobe latches bank and row; one strobe per group of eight DIMMs.
// - The low column strobe latches bank and column; one strobe per group.
// - The low write enable marks a write, high a read; one per group.
// - Each transfer moves 72 data bits, 64 payload and 8 check bits.
// - Each carrier has three two-wire buses: FRU/sensor, lower SPD slots, upper SPD slots.
`timescale 1ns/1ps
`include "dpsd_defs.svh"
module dpsd_ctrl (
  // Clock and reset.
  input  wire logic               mclk_in,
  input  wire logic               rst_in,
  // Access requests.
  input  wire logic               req_valid_in,
  input  wire dpsd_pkg::dpsd_req_t req_in,
  output logic                    req_ready_out,
  // Read answers.
  output logic                    rsp_valid_out,
  output dpsd_pkg::dpsd_rsp_t     rsp_out,
  input  wire logic               rsp_ready_in,
  // Primary carrier.
  output logic [1:0]              primary_bank_addr_out,
  output logic [12:0]             primary_mux_addr_out,
  output logic [7:0]              primary_chip_select_n_out,
  output logic [3:0]              primary_row_strobe_n_out,
  output logic [3:0]              primary_col_strobe_n_out,
  output logic [3:0]              primary_write_enable_n_out,
  output logic [63:0]             primary_data_n_out,
  output logic [7:0]              primary_check_bits_n_out,
  output logic                    primary_data_oe_out,
  input  wire logic [63:0]        primary_data_n_in,
  input  wire logic [7:0]         primary_check_bits_n_in,
  // Secondary carrier.
  output logic [1:0]              secondary_bank_addr_out,
  output logic [12:0]             secondary_mux_addr_out,
  output logic [7:0]              secondary_chip_select_n_out,
  output logic [3:0]              secondary_row_strobe_n_out,
  output logic [3:0]              secondary_col_strobe_n_out,
  output logic [3:0]              secondary_write_enable_n_out,
  output logic [63:0]             secondary_data_n_out,
  output logic [7:0]              secondary_check_bits_n_out,
  output logic                    secondary_data_oe_out,
  input  wire logic [63:0]        secondary_data_n_in,
  input  wire logic [7:0]         secondary_check_bits_n_in,
  // Two-wire buses, index carrier*3 + bus; user levels in, pins out.
  input  wire logic [5:0]         mgmt_scl_in,
  input  wire logic [5:0]         mgmt_sda_pull_low_in,
  output logic [5:0]              mgmt_sda_level_out,
  output logic [5:0]              two_wire_scl_out,
  output logic [5:0]              two_wire_sda_out,
  output logic [5:0]              two_wire_sda_oe_out,
  input  wire logic [5:0]         two_wire_sda_in,
  // Carrier housekeeping.
  output logic                    scan_reset_n_out,
  output logic                    buffered_power_good_out
);
  import dpsd_pkg::*;

  // ****************************************************************
  // Check-bit code
  // ****************************************************************

  // Column of data bit j: the j-th 7-bit value of weight two or more.
  function automatic logic [6:0] ecc_col(input int j);
    int k;
    logic [6:0] r;
    k = 0;
    r = 7'h00;
    for (int v = 3; v < 128; v++) begin
      if ($countones(v) > 1) begin
        if (k == j) begin
          r = v[6:0];
        end
        k++;
      end
    end
    return r;
  endfunction

  // Seven syndrome bits plus one overall parity bit.
  function automatic logic [7:0] ecc_gen(input logic [63:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int j = 0; j < 64; j++) begin
      if (d[j]) begin
        c = c ^ ecc_col(j);
      end
    end
    return {^{d, c}, c};
  endfunction

  // Corrects one flipped bit and flags two.
  function automatic dpsd_rsp_t ecc_fix(input logic [63:0] d, input logic [7:0] ck);
    dpsd_rsp_t  r;
    logic [7:0] gen;
    logic [6:0] syn;
    logic       par;
    gen = ecc_gen(d);
    syn = gen[6:0] ^ ck[6:0];
    par = ^{d, ck};
    r.data = d;
    r.corrected = par;
    r.uncorrectable = (syn != 7'h00) && !par;
    for (int j = 0; j < 64; j++) begin
      if (par && (syn == ecc_col(j))) begin
        r.data[j] = !d[j];
      end
    end
    return r;
  endfunction

  // One-hot active-low select out of a binary index.
  function automatic logic [7:0] sel_n(input logic [2:0] idx);
    return ~(8'h01 << idx);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  dpsd_regs_t r_r;
  dpsd_regs_t r_nxt;
  dpsd_pins_t idle_pins;
  dpsd_pins_t cmd_pins;
  dpsd_rsp_t  rd_word;
  logic       accept;
  logic       pop;

  // Quiet pin set: all selects and strobes high, data not driven.
  always_comb begin
    idle_pins = '0;
    idle_pins.chip_select_n = `DPSD_CS_OFF;
    idle_pins.row_strobe_n = `DPSD_STROBE_OFF;
    idle_pins.col_strobe_n = `DPSD_STROBE_OFF;
    idle_pins.write_enable_n = `DPSD_STROBE_OFF;
  end

  // Reads only start with a free buffer slot, so a stalled reader loses nothing.
  assign accept = req_valid_in && req_ready_out;
  assign req_ready_out = (r_r.st == ST_IDLE) && (r_r.fill != `DPSD_BUF_DEPTH);
  assign pop = rsp_valid_out && rsp_ready_in;
  assign rsp_valid_out = (r_r.fill != 2'h0);
  assign rd_word = r_r.req.port ?
                   ecc_fix(~secondary_data_n_in, ~secondary_check_bits_n_in) :
                   ecc_fix(~primary_data_n_in, ~primary_check_bits_n_in);

  // Next state of the access engine, answer buffer and side buses.
  always_comb begin
    r_nxt = r_r;
    cmd_pins = idle_pins;
    r_nxt.pgood = 1'b1;
    r_nxt.scl = mgmt_scl_in;
    r_nxt.sda_oe = mgmt_sda_pull_low_in;
    r_nxt.sda_rd = two_wire_sda_in;
    case (r_r.st)
      ST_IDLE: begin
        if (accept) begin
          r_nxt.req = req_in;
          r_nxt.cnt = 3'(`DPSD_TRCD_CYC);
          cmd_pins.bank_addr = req_in.bank;
          cmd_pins.mux_addr = req_in.row;
          cmd_pins.chip_select_n = sel_n(req_in.dimm[2:0]);
          cmd_pins.row_strobe_n = 4'(sel_n({1'b0, req_in.dimm[4:3]}));
          r_nxt.st = ST_ACT;
        end
      end
      ST_ACT: begin
        if (r_r.cnt <= 3'h1) begin
          cmd_pins.bank_addr = r_r.req.bank;
          cmd_pins.mux_addr = r_r.req.col;
          cmd_pins.chip_select_n = sel_n(r_r.req.dimm[2:0]);
          cmd_pins.col_strobe_n = 4'(sel_n({1'b0, r_r.req.dimm[4:3]}));
          if (r_r.req.wr) begin
            cmd_pins.write_enable_n = 4'(sel_n({1'b0, r_r.req.dimm[4:3]}));
            cmd_pins.data_oe = 1'b1;
            cmd_pins.data_n = ~r_r.req.wdata;
            cmd_pins.check_bits_n = ~ecc_gen(r_r.req.wdata);
          end
          r_nxt.st = ST_CMD;
        end else begin
          r_nxt.cnt = r_r.cnt - 3'h1;
        end
      end
      ST_CMD: begin
        r_nxt.cnt = `DPSD_CAS_LAT;
        r_nxt.st = r_r.req.wr ? ST_IDLE : ST_WAIT;
      end
      ST_WAIT: begin
        if (r_r.cnt <= 3'h1) begin
          r_nxt.fifo[r_r.wptr] = rd_word;
          r_nxt.wptr = !r_r.wptr;
          r_nxt.st = ST_IDLE;
        end else begin
          r_nxt.cnt = r_r.cnt - 3'h1;
        end
      end
      default: begin
        r_nxt.st = ST_IDLE;
      end
    endcase
    // Only the addressed carrier sees the command; the other stays quiet.
    r_nxt.pri = (cmd_pins != idle_pins) && !((r_r.st == ST_IDLE) ? req_in.port :
                r_r.req.port) ? cmd_pins : idle_pins;
    r_nxt.sec = (cmd_pins != idle_pins) && ((r_r.st == ST_IDLE) ? req_in.port :
                r_r.req.port) ? cmd_pins : idle_pins;
    if (pop) begin
      r_nxt.rptr = !r_r.rptr;
    end
    r_nxt.fill = r_r.fill + 2'((r_r.st == ST_WAIT) && (r_r.cnt <= 3'h1)) - 2'(pop);
  end

  // Register the whole state.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      r_r <= '0;
      r_r.pri <= idle_pins;
      r_r.sec <= idle_pins;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rsp_out = r_r.fifo[r_r.rptr];
  assign primary_bank_addr_out = r_r.pri.bank_addr;
  assign primary_mux_addr_out = r_r.pri.mux_addr;
  assign primary_chip_select_n_out = r_r.pri.chip_select_n;
  assign primary_row_strobe_n_out = r_r.pri.row_strobe_n;
  assign primary_col_strobe_n_out = r_r.pri.col_strobe_n;
  assign primary_write_enable_n_out = r_r.pri.write_enable_n;
  assign primary_data_n_out = r_r.pri.data_n;
  assign primary_check_bits_n_out = r_r.pri.check_bits_n;
  assign primary_data_oe_out = r_r.pri.data_oe;
  assign secondary_bank_addr_out = r_r.sec.bank_addr;
  assign secondary_mux_addr_out = r_r.sec.mux_addr;
  assign secondary_chip_select_n_out = r_r.sec.chip_select_n;
  assign secondary_row_strobe_n_out = r_r.sec.row_strobe_n;
  assign secondary_col_strobe_n_out = r_r.sec.col_strobe_n;
  assign secondary_write_enable_n_out = r_r.sec.write_enable_n;
  assign secondary_data_n_out = r_r.sec.data_n;
  assign secondary_check_bits_n_out = r_r.sec.check_bits_n;
  assign secondary_data_oe_out = r_r.sec.data_oe;
  // Open drain: the data line is only ever pulled low, never driven high.
  assign two_wire_scl_out = r_r.scl;
  assign two_wire_sda_out = 6'h00;
  assign two_wire_sda_oe_out = r_r.sda_oe;
  assign mgmt_sda_level_out = r_r.sda_rd;
  // Keeps the carrier's test port in reset outside board test.
  assign scan_reset_n_out = `DPSD_SCAN_RESET;
  assign buffered_power_good_out = r_r.pgood;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_row_strobe_one: assert property (@(posedge mclk_in) disable iff (rst_in)
    $onehot0(~r_r.pri.row_strobe_n) && $onehot0(~r_r.sec.row_strobe_n))
    else $error("more than one row strobe active");
  a_col_strobe_one: assert property (@(posedge mclk_in) disable iff (rst_in)
    $onehot0(~r_r.pri.col_strobe_n) && $onehot0(~r_r.sec.col_strobe_n))
    else $error("more than one column strobe active");
  a_chip_select_one: assert property (@(posedge mclk_in) disable iff (rst_in)
    $onehot0(~r_r.pri.chip_select_n) && $onehot0(~r_r.sec.chip_select_n))
    else $error("more than one chip select active");
  a_other_port_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
    !(&r_r.pri.chip_select_n) |-> (&r_r.sec.chip_select_n))
    else $error("both carriers selected at once");
  a_act_row_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
    (accept && !req_in.port) |=> (primary_mux_addr_out == $past(req_in.row)) &&
    !primary_row_strobe_n_out[$past(req_in.dimm[4:3])] &&
    !primary_chip_select_n_out[$past(req_in.dimm[2:0])])
    else $error("activate does not match the request");
  a_col_follows_act: assert property (@(posedge mclk_in) disable iff (rst_in)
    (accept && !req_in.port) |-> ##[2:5] (primary_col_strobe_n_out != `DPSD_STROBE_OFF))
    else $error("column strobe missing after activate");
  a_read_no_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    (r_r.st == ST_CMD && !r_r.req.wr) |-> (&r_r.pri.write_enable_n) &&
    (&r_r.sec.write_enable_n) && !r_r.pri.data_oe && !r_r.sec.data_oe)
    else $error("write enable or data driven on a read");
  a_write_check_bits: assert property (@(posedge mclk_in) disable iff (rst_in)
    r_r.pri.data_oe |-> (~primary_check_bits_n_out == ecc_gen(~primary_data_n_out)))
    else $error("check bits do not match written word");
  a_read_answer: assert property (@(posedge mclk_in) disable iff (rst_in)
    (accept && !req_in.wr && !rsp_ready_in) |-> ##[4:6] rsp_valid_out)
    else $error("read answer not buffered in time");
  a_scan_reset_low: assert property (@(posedge mclk_in) disable iff (rst_in)
    !scan_reset_n_out)
    else $error("scan reset released");
endmodule

// *** verilog/dpsd_defs.svh ***
// Constants of the dual-port SDRAM carrier interface.
`ifndef DPSD_DEFS_SVH
`define DPSD_DEFS_SVH
`define DPSD_CLK_MHZ      10
`define DPSD_TRCD_NS      20
`define DPSD_TRCD_CYC     (((`DPSD_TRCD_NS) * (`DPSD_CLK_MHZ) + 999) / 1000)
`define DPSD_CAS_LAT      3'h2
`define DPSD_BUF_DEPTH    2'h2
`define DPSD_BUS_FRU      0
`define DPSD_BUS_LOWER    1
`define DPSD_BUS_UPPER    2
`define DPSD_BUSES        6
`define DPSD_STROBE_OFF   4'hf
`define DPSD_CS_OFF       8'hff
`define DPSD_SCAN_RESET   1'b0
`endif

// *** verilog/dpsd_pkg.sv ***
// Types of the dual-port SDRAM carrier interface.
package dpsd_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ACT, ST_CMD, ST_WAIT} dpsd_state_t;
  typedef struct packed {
    logic        port;   // 0 primary carrier, 1 secondary carrier.
    logic [4:0]  dimm;   // Strobe group in [4:3], chip select in [2:0].
    logic [1:0]  bank;
    logic [12:0] row;
    logic [12:0] col;
    logic        wr;
    logic [63:0] wdata;
  } dpsd_req_t;
  typedef struct packed {
    logic [63:0] data;
    logic        corrected;
    logic        uncorrectable;
  } dpsd_rsp_t;
  typedef struct packed {
    logic [1:0]  bank_addr;
    logic [12:0] mux_addr;
    logic [7:0]  chip_select_n;
    logic [3:0]  row_strobe_n;
    logic [3:0]  col_strobe_n;
    logic [3:0]  write_enable_n;
    logic        data_oe;
    logic [63:0] data_n;
    logic [7:0]  check_bits_n;
  } dpsd_pins_t;
  typedef struct packed {
    dpsd_state_t    st;
    dpsd_req_t      req;
    logic [2:0]     cnt;
    dpsd_pins_t     pri;
    dpsd_pins_t     sec;
    dpsd_rsp_t [1:0] fifo;
    logic           wptr;
    logic           rptr;
    logic [1:0]     fill;
    logic [5:0]     scl;
    logic [5:0]     sda_oe;
    logic [5:0]     sda_rd;
    logic           pgood;
  } dpsd_regs_t;
endpackage

// *** dv/dpsd_dimm_model.sv ***
// Behavioural SDRAM DIMM population behind one memory port.
`timescale 1ns/1ps
module dpsd_dimm_model (
  // Clock.
  input  wire logic        mclk_in,
  // Command and address pins, strobes active low, bank above address.
  input  wire logic [7:0]  cs_n_in,
  input  wire logic [3:0]  ras_n_in,
  input  wire logic [3:0]  cas_n_in,
  input  wire logic [3:0]  we_n_in,
  input  wire logic [14:0] addr_in,
  // Data pins, check bits above the payload; flip_in corrupts read answers.
  input  wire logic [71:0] wr_n_in,
  input  wire logic [71:0] flip_in,
  output logic      [71:0] rd_n_out
);
  logic [71:0] mem [logic [39:0]];
  logic [12:0] row_r [4];
  logic [39:0] key_r;
  logic [39:0] key;
  logic [1:0]  pipe_r;
  // The select pattern is part of the key, so a wrong decode never reads back.
  initial begin
    pipe_r = 2'h0;
    rd_n_out = '1;
  end
  // Read data comes two edges after the column command and holds one cycle only.
  // After that the bus shows the inverse, so a late sample never sees a stale word.
  always @(posedge mclk_in) begin
    pipe_r <= {pipe_r[0], 1'b0};
    for (int g = 0; g < 4; g++) begin
      if (!ras_n_in[g]) row_r[g] <= addr_in[12:0];
      if (!cas_n_in[g]) begin
        key = {cs_n_in, cas_n_in, addr_in[14:13], row_r[g], addr_in[12:0]};
        key_r <= key;
        if (!we_n_in[g]) mem[key] = ~wr_n_in;
        else pipe_r[0] <= 1'b1;
      end
    end
    if (pipe_r[0]) rd_n_out <= ~((mem.exists(key_r) ? mem[key_r] : 72'h0) ^ flip_in);
    else if (pipe_r[1]) rd_n_out <= ~rd_n_out;
  end
endmodule

// *** dv/tb_top.sv ***
// Self-checking testbench of the dual-port SDRAM carrier controller.
`timescale 1ns/1ps
module tb_top;
  import dpsd_pkg::*;
  logic mclk_in, rst_in, req_valid_in, rsp_ready_in, req_ready_out, rsp_valid_out;
  logic scan_n, pgood;
  dpsd_req_t req_in;
  dpsd_rsp_t rsp_out;
  wire  [1:0][1:0]  ba;
  wire  [1:0][12:0] ma;
  wire  [1:0][7:0]  cs_n;
  wire  [1:0][3:0]  ras_n, cas_n, we_n;
  wire  [1:0][71:0] wr_n, rd_n;
  wire  [1:0]       oe;
  logic [1:0][71:0] flip;
  logic [5:0]       scl_u, pull_u, sda_lvl, tw_scl, tw_sda, tw_oe;
  int               n_mismatch = 0;
  int               cmp_count = 0;
  logic [4:0]       dm [4] = '{5'h00, 5'h09, 5'h16, 5'h1f};

  // ************************************************
  // Design, DIMM models and clock
  // ************************************************
  // The two-wire line has a pull-up, so it is low only while the block pulls.
  dpsd_ctrl dpsd_ctrl_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out),
    .rsp_ready_in(rsp_ready_in), .primary_bank_addr_out(ba[0]), .primary_mux_addr_out(ma[0]),
    .primary_chip_select_n_out(cs_n[0]), .primary_row_strobe_n_out(ras_n[0]),
    .primary_col_strobe_n_out(cas_n[0]), .primary_write_enable_n_out(we_n[0]),
    .primary_data_n_out(wr_n[0][63:0]), .primary_check_bits_n_out(wr_n[0][71:64]),
    .primary_data_oe_out(oe[0]), .primary_data_n_in(rd_n[0][63:0]),
    .primary_check_bits_n_in(rd_n[0][71:64]),
    .secondary_bank_addr_out(ba[1]), .secondary_mux_addr_out(ma[1]),
    .secondary_chip_select_n_out(cs_n[1]), .secondary_row_strobe_n_out(ras_n[1]),
    .secondary_col_strobe_n_out(cas_n[1]), .secondary_write_enable_n_out(we_n[1]),
    .secondary_data_n_out(wr_n[1][63:0]), .secondary_check_bits_n_out(wr_n[1][71:64]),
    .secondary_data_oe_out(oe[1]), .secondary_data_n_in(rd_n[1][63:0]),
    .secondary_check_bits_n_in(rd_n[1][71:64]),
    .mgmt_scl_in(scl_u), .mgmt_sda_pull_low_in(pull_u), .mgmt_sda_level_out(sda_lvl),
    .two_wire_scl_out(tw_scl), .two_wire_sda_out(tw_sda), .two_wire_sda_oe_out(tw_oe),
    .two_wire_sda_in(~tw_oe), .scan_reset_n_out(scan_n), .buffered_power_good_out(pgood)
  );
  // One DIMM population per carrier.
  for (genvar p = 0; p < 2; p++) begin : g_dimm
    dpsd_dimm_model dpsd_dimm_model_i (
      .mclk_in(mclk_in), .cs_n_in(cs_n[p]), .ras_n_in(ras_n[p]), .cas_n_in(cas_n[p]),
      .we_n_in(we_n[p]), .addr_in({ba[p], ma[p]}), .wr_n_in(wr_n[p]), .flip_in(flip[p]),
      .rd_n_out(rd_n[p])
    );
  end
  // Free-running 10 MHz clock.
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Write for k below 8, read of the same place for k from 8; every strobe group is hit.
  function automatic dpsd_req_t rq(input int k);
    logic [2:0] j;
    j = k[2:0];
    return '{k[2], dm[k & 3], k[1:0], {10'h3ff, j}, {10'h000, j}, ~k[3],
             {32'hc3a50f96, 29'h0, j}};
  endfunction
  // Issues one access and checks the row phase, then the column phase one cycle later.
  task automatic access(input dpsd_req_t r);
    int n;
    int p;
    logic [3:0] g;
    logic [7:0] c;
    n = 0;
    p = r.port;
    g = ~(4'h1 << r.dimm[4:3]);
    c = ~(8'h1 << r.dimm[2:0]);
    @(posedge mclk_in);
    req_valid_in <= 1'b1;
    req_in <= r;
    @(negedge mclk_in);
    while (req_ready_out !== 1'b1 && n < 20) begin
      @(negedge mclk_in);
      n++;
    end
    check(n < 20, 1'b1);
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    @(negedge mclk_in);
    check({ras_n[p], cs_n[p], cas_n[p], we_n[p]}, {g, c, 8'hff});
    check({ba[p], ma[p]}, {r.bank, r.row});
    check({ras_n[1 - p], cs_n[1 - p]}, 12'hfff);
    @(negedge mclk_in);
    check({cas_n[p], ras_n[p], cs_n[p], we_n[p]}, {g, 4'hf, c, r.wr ? g : 4'hf});
    check({ba[p], ma[p], oe[p]}, {r.bank, r.col, r.wr});
    if (r.wr) check(wr_n[p][63:0], 64'(~r.wdata));
  endtask
  // Waits for a read answer, judges it and pops it.
  task automatic take(input logic [63:0] d, input logic [1:0] fl, input bit full);
    int n;
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 10) begin
      @(negedge mclk_in);
      n++;
    end
    check(n <= 3, 1'b1);
    check({rsp_valid_out, rsp_out.corrected, rsp_out.uncorrectable}, {1'b1, fl});
    if (full) check(rsp_out.data, d);
    @(posedge mclk_in);
    rsp_ready_in <= 1'b1;
    @(posedge mclk_in);
    rsp_ready_in <= 1'b0;
    @(negedge mclk_in);
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_reset();
    @(negedge mclk_in);
    check({ras_n, cas_n, we_n, cs_n, oe, rsp_valid_out, pgood}, {40'hffffffffff, 4'h0});
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    @(negedge mclk_in);
    check({pgood, req_ready_out, scan_n}, 3'b110);
  endtask
  task automatic t_rw();
    dpsd_req_t r;
    for (int k = 0; k < 16; k++) begin
      r = rq(k);
      access(r);
      if (k > 7) take(r.wdata, 2'b00, 1'b1);
    end
  endtask
  // One flipped data bit, one flipped check bit, then two flipped bits.
  task automatic t_ecc();
    logic [71:0] m [3] = '{72'h8, 72'h4 << 64, 72'h3 << 10};
    logic [1:0] f [3] = '{2'b10, 2'b10, 2'b01};
    dpsd_req_t r;
    r = '{1'b1, 5'h05, 2'h1, 13'h0aaa, 13'h1555, 1'b1, 64'h5a5a0ff012348001};
    access(r);
    r.wr = 1'b0;
    for (int i = 0; i < 3; i++) begin
      flip[1] <= m[i];
      access(r);
      take(r.wdata, f[i], i < 2);
    end
    flip[1] <= '0;
  endtask
  // The consumer stalls until both buffer entries are full.
  task automatic t_buffer();
    dpsd_req_t a;
    dpsd_req_t b;
    a = rq(9);
    b = rq(10);
    access(a);
    access(b);
    repeat (6) @(negedge mclk_in);
    check(req_ready_out, 1'b0);
    take(a.wdata, 2'b00, 1'b1);
    check(req_ready_out, 1'b1);
    take(b.wdata, 2'b00, 1'b1);
    check(rsp_valid_out, 1'b0);
  endtask
  task automatic t_wires();
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_in);
      scl_u <= 6'h1 << i;
      pull_u <= 6'h3f ^ (6'h1 << i);
      @(posedge mclk_in);
      @(negedge mclk_in);
      check({tw_scl, tw_oe, tw_sda}, {6'h1 << i, 6'h3f ^ (6'h1 << i), 6'h0});
      @(negedge mclk_in);
      check(sda_lvl, 6'h1 << i);
    end
  endtask
  // Main sequence.
  initial begin
    rst_in = 1'b1;
    req_valid_in = 1'b0;
    req_in = '0;
    rsp_ready_in = 1'b0;
    scl_u = 6'h0;
    pull_u = 6'h0;
    flip = '0;
    t_reset();
    t_rw();
    t_ecc();
    t_buffer();
    t_wires();
    complete_run();
  end
  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_mismatch++;
    complete_run();
  end
endmodule
